// >>> core/dpsc_edge.sv
`timescale 1ns/1ps
`default_nettype none
module dpsc_edge #(
  parameter int WIDTH = 1
) (
  input  wire logic             MCLK,
  input  wire logic             RST_N,
  input  wire logic [WIDTH-1:0] D,
  output logic      [WIDTH-1:0] RISE
);
  logic [WIDTH-1:0] prev_ff;

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
        prev_ff[i] <= 1'b0;
      end else begin
        prev_ff[i] <= D[i];
      end
    end
    assign RISE[i] = D[i] & ~prev_ff[i];
  end
endmodule : dpsc_edge
`default_nettype wire

// >>> core/dpsc_map.svh
`ifndef DPSC_MAP_SVH
`define DPSC_MAP_SVH

`define DPSC_OFS_RESET_REQ   8'h08
`define DPSC_OFS_SYS_CTRL    8'h0A
`define DPSC_OFS_SYS_STATUS  8'h0B
`define DPSC_OFS_CRC_STATUS  8'h0C

`define DPSC_RST_SIGNATURE   8'h59
`define DPSC_RST_RUN         8'h00

`define DPSC_CTRL_SYS_CLOCK_REQUEST_BIT 0
`define DPSC_CTRL_UDONE_BIT  1

`define DPSC_STAT_LOCK_BIT   0
`define DPSC_STAT_UPROG_BIT  2
`define DPSC_STAT_NPROG_BIT  3
`define DPSC_STAT_SLEEP_BIT  4
`define DPSC_STAT_SYSTEM_RESET_ACTIVE_BIT 5
`define DPSC_STAT_EFAIL_BIT  6

`define DPSC_STATUS_RESET    8'h01
`define DPSC_CRC_RESET       3'h0
`define DPSC_CRC_OFF         3'h0
`define DPSC_CRC_BUSY        3'h1
`define DPSC_CRC_OK          3'h2
`define DPSC_CRC_FAIL        3'h4
`endif

// >>> core/dpsc_pkg.sv
package dpsc_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dpsc_req_t;

  typedef struct packed {
    logic       rvalid;
    logic [7:0] rdata;
  } dpsc_rsp_t;

  typedef struct packed {
    logic       dbg_en;
    logic       erase_fail;
    logic       reset_active;
    logic       in_sleep;
    logic       nvm_ready;
    logic       urow_ready;
    logic       locked;
    logic       urow_key;
    logic       staged;
    logic [2:0] crc;
  } dpsc_sys_t;

  typedef enum logic [2:0] {
    DPSC_ST_IDLE  = 3'b001,
    DPSC_ST_START = 3'b010,
    DPSC_ST_HOLD  = 3'b100
  } dpsc_state_t;
endpackage : dpsc_pkg

// >>> core/dpsc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dpsc_sync #(
  parameter int              WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             MCLK,
  input  wire logic             RST_N,
  input  wire logic [WIDTH-1:0] D,
  output logic      [WIDTH-1:0] Q
);
  logic [WIDTH-1:0] meta_ff;

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
        meta_ff[i] <= RST_VAL[i];
        Q[i]       <= RST_VAL[i];
      end else begin
        meta_ff[i] <= D[i];
        Q[i]       <= meta_ff[i];
      end
    end
  end
endmodule : dpsc_sync
`default_nettype wire

// >>> core/dpsc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dpsc_map.svh"
module dpsc_top
  import dpsc_pkg::*;
(
  input  wire logic      MCLK,
  input  wire logic      RST_N,
  input  wire dpsc_req_t REQ,
  output var  dpsc_rsp_t RSP,
  input  wire dpsc_sys_t SYS_IN,
  output logic           SYS_CLK_REQ,
  output logic           SYS_RESET_REQ,
  output logic           UROW_START,
  output logic           UROW_STAGED
);

  // The lock input syncs out of reset as locked, so the status never
  // shows an unlocked device before the real lock state arrives.
  localparam dpsc_sys_t SYS_RST_VAL = '{
    dbg_en:       1'b0,
    erase_fail:   1'b0,
    reset_active: 1'b0,
    in_sleep:     1'b0,
    nvm_ready:    1'b0,
    urow_ready:   1'b0,
    locked:       1'b1,
    urow_key:     1'b0,
    staged:       1'b0,
    crc:          `DPSC_CRC_RESET
  };

  dpsc_sys_t   sys_s;
  logic [1:0]  rise;
  logic        dbg_en_rise;
  logic        erase_fail_rise;

  logic [7:0]  rst_req_ff;
  logic        rst_hold_ff;
  logic        clk_req_ff;
  logic        erase_failed_ff;
  logic        sys_rst_seen_ff;
  logic        locked_ff;
  logic        in_sleep_ff;
  logic        nvm_allowed_ff;
  logic        urow_allowed_ff;
  logic [2:0]  crc_ff;
  logic [2:0]  crc_prev_ff;
  logic        staged_ff;
  dpsc_state_t state_ff;
  dpsc_state_t nxt_state;
  logic        urow_start_ff;
  logic [7:0]  rdata_ff;
  logic        rvalid_ff;
  logic [7:0]  nxt_rdata;

  logic        wr_rst_req;
  logic        wr_ctrl;
  logic        rd_status;
  logic        reset_in_system;
  logic        udone_accept;
  logic        crc_legal;
  logic [7:0]  status_word;
  logic [7:0]  ctrl_word;

  // All system-side levels are asynchronous to the debug clock.
  dpsc_sync #(
    .WIDTH   ($bits(dpsc_sys_t)),
    .RST_VAL (SYS_RST_VAL)
  ) u_sync (
    .MCLK  (MCLK),
    .RST_N (RST_N),
    .D     (SYS_IN),
    .Q     (sys_s)
  );

  dpsc_edge #(
    .WIDTH (2)
  ) u_edge (
    .MCLK  (MCLK),
    .RST_N (RST_N),
    .D     ({sys_s.dbg_en, sys_s.erase_fail}),
    .RISE  (rise)
  );

  assign dbg_en_rise     = rise[1];
  assign erase_fail_rise = rise[0];

  assign wr_rst_req = REQ.wr && (REQ.addr == `DPSC_OFS_RESET_REQ);
  assign wr_ctrl    = REQ.wr && (REQ.addr == `DPSC_OFS_SYS_CTRL);
  assign rd_status  = REQ.rd && (REQ.addr == `DPSC_OFS_SYS_STATUS);

  // Our own held request counts as a system reset even before the
  // system side reports it back through the synchroniser.
  assign reset_in_system = sys_s.reset_active | SYS_RESET_REQ;

  // Reset request register. Reserved values are dropped so that a stray
  // write can neither assert nor release the system reset.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_req_ff <= `DPSC_RST_RUN;
    end else if (wr_rst_req) begin
      if (REQ.wdata == `DPSC_RST_SIGNATURE ||
          REQ.wdata == `DPSC_RST_RUN) begin
        rst_req_ff <= REQ.wdata;
      end
    end
  end

  // Only this debug block's reset clears the register, so the system
  // reset it drives never resets the debug side itself.
  // The reset line comes straight from a flop, because a decode of the
  // stored byte could glitch while it changes and fire a false reset.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_hold_ff <= 1'b0;
    end else if (wr_rst_req) begin
      if (REQ.wdata == `DPSC_RST_SIGNATURE) begin
        rst_hold_ff <= 1'b1;
      end else if (REQ.wdata == `DPSC_RST_RUN) begin
        rst_hold_ff <= 1'b0;
      end
    end
  end

  assign SYS_RESET_REQ = rst_hold_ff;

  // Clock request: forced on at each enable, dropped while disabled.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      clk_req_ff <= 1'b0;
    end else if (!sys_s.dbg_en) begin
      clk_req_ff <= 1'b0;
    end else if (dbg_en_rise) begin
      clk_req_ff <= 1'b1;
    end else if (wr_ctrl) begin
      clk_req_ff <= REQ.wdata[`DPSC_CTRL_SYS_CLOCK_REQUEST_BIT];
    end
  end

  assign SYS_CLK_REQ = clk_req_ff;

  // User-row commit sequencer.
  assign udone_accept = wr_ctrl && REQ.wdata[`DPSC_CTRL_UDONE_BIT]
                        && sys_s.urow_key;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      DPSC_ST_IDLE: begin
        if (udone_accept) begin
          nxt_state = DPSC_ST_START;
        end
      end
      DPSC_ST_START: begin
        nxt_state = DPSC_ST_HOLD;
      end
      DPSC_ST_HOLD: begin
        // Wait for the key to drop so one session gives one commit.
        if (!sys_s.urow_key) begin
          nxt_state = DPSC_ST_IDLE;
        end
      end
      default: begin
        nxt_state = DPSC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff <= DPSC_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // The start strobe is registered so the Flash side never sees a
  // glitch while two bits of the one-hot state move at once.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      urow_start_ff <= 1'b0;
    end else begin
      urow_start_ff <= (nxt_state == DPSC_ST_START);
    end
  end

  assign UROW_START = urow_start_ff;

  // The staged flag is captured with the commit; when it is low the
  // system proceeds without the RAM contents instead of stalling.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      staged_ff <= 1'b0;
    end else if (state_ff == DPSC_ST_IDLE && udone_accept) begin
      staged_ff <= sys_s.staged;
    end
  end

  assign UROW_STAGED = staged_ff;

  // Erase failure is sticky; a new failure wins over a reset clear.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      erase_failed_ff <= 1'b0;
    end else if (erase_fail_rise) begin
      erase_failed_ff <= 1'b1;
    end else if (reset_in_system) begin
      erase_failed_ff <= 1'b0;
    end
  end

  // Reset-active is held until read; a reset still present on the read
  // cycle keeps it set, so no reset goes unseen.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      sys_rst_seen_ff <= 1'b0;
    end else if (reset_in_system) begin
      sys_rst_seen_ff <= 1'b1;
    end else if (rd_status) begin
      sys_rst_seen_ff <= 1'b0;
    end
  end

  // Plain status levels follow the system side, a few cycles late.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      in_sleep_ff <= 1'b0;
    end else begin
      in_sleep_ff <= sys_s.in_sleep;
    end
  end

  // Programming permission is only mirrored here; the key decode that
  // grants it lives on the system side.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      nvm_allowed_ff <= 1'b0;
    end else begin
      nvm_allowed_ff <= sys_s.nvm_ready;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      urow_allowed_ff <= 1'b0;
    end else begin
      urow_allowed_ff <= sys_s.urow_ready;
    end
  end

  // Lock reads one from reset and follows the lock bits after erase.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      locked_ff <= 1'b1;
    end else begin
      locked_ff <= sys_s.locked;
    end
  end

  // Only the legal codes, zero and the one-hot codes, are taken; a reserved code seen during
  // a transition holds the previous status instead of showing garbage.
  always_comb begin
    case (sys_s.crc)
      `DPSC_CRC_OFF,
      `DPSC_CRC_BUSY,
      `DPSC_CRC_OK,
      `DPSC_CRC_FAIL: crc_legal = 1'b1;
      default:        crc_legal = 1'b0;
    endcase
  end

  // A change between one-hot codes moves two bits that the synchroniser
  // may catch on different edges, so a code is taken only once two
  // samples agree. This costs one cycle of latency on the status.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      crc_prev_ff <= `DPSC_CRC_RESET;
    end else begin
      crc_prev_ff <= sys_s.crc;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      crc_ff <= `DPSC_CRC_RESET;
    end else if (crc_legal && (sys_s.crc == crc_prev_ff)) begin
      crc_ff <= sys_s.crc;
    end
  end

  // Read-back words; reserved bits read zero.
  always_comb begin
    status_word = 8'h00;
    status_word[`DPSC_STAT_EFAIL_BIT]  = erase_failed_ff;
    status_word[`DPSC_STAT_SYSTEM_RESET_ACTIVE_BIT] = sys_rst_seen_ff;
    status_word[`DPSC_STAT_SLEEP_BIT]  = in_sleep_ff;
    status_word[`DPSC_STAT_NPROG_BIT]  = nvm_allowed_ff;
    status_word[`DPSC_STAT_UPROG_BIT]  = urow_allowed_ff;
    status_word[`DPSC_STAT_LOCK_BIT]   = locked_ff;
  end

  always_comb begin
    ctrl_word = 8'h00;
    ctrl_word[`DPSC_CTRL_SYS_CLOCK_REQUEST_BIT] = clk_req_ff;
  end

  // Writes to the status and checksum offsets have no decode at all.
  always_comb begin
    case (REQ.addr)
      `DPSC_OFS_RESET_REQ:  nxt_rdata = rst_req_ff;
      `DPSC_OFS_SYS_CTRL:   nxt_rdata = ctrl_word;
      `DPSC_OFS_SYS_STATUS: nxt_rdata = status_word;
      `DPSC_OFS_CRC_STATUS: nxt_rdata = {5'h00, crc_ff};
      default:              nxt_rdata = 8'h00;
    endcase
  end

  // Read data is registered; the value returned is the one from before
  // any clear-on-read taking effect at the same edge.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_ff <= 8'h00;
    end else if (REQ.rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= REQ.rd;
    end
  end

  assign RSP.rvalid = rvalid_ff;
  assign RSP.rdata  = rdata_ff;

endmodule : dpsc_top
`default_nettype wire

// >>> test/dpsc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module dpsc_checker
  import dpsc_pkg::*;
(
  input wire logic      MCLK,
  input wire logic      RST_N,
  input wire dpsc_req_t REQ,
  input wire dpsc_rsp_t RSP,
  input wire dpsc_sys_t SYS_IN,
  input wire logic      SYS_CLK_REQ,
  input wire logic      SYS_RESET_REQ,
  input wire logic      UROW_START,
  input wire logic      UROW_STAGED
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  sequence s_urow_cmd;
    REQ.wr && REQ.addr == 8'h0A && REQ.wdata[1];
  endsequence
  sequence s_rst_wr;
    REQ.wr && REQ.addr == 8'h08;
  endsequence
  chk_crc_field: assert property (
    REQ.rd && REQ.addr == 8'h0C |=> RSP.rvalid && RSP.rdata[7:3] == 5'h00)
    else $error("checksum read malformed");
  chk_reset_assert: assert property (
    s_rst_wr ##0 REQ.wdata == 8'h59 |=> SYS_RESET_REQ)
    else $error("reset signature not applied");
  chk_reset_release: assert property (
    s_rst_wr ##0 REQ.wdata == 8'h00 |=> !SYS_RESET_REQ)
    else $error("reset not released");
  chk_urow_pulse: assert property (
    s_urow_cmd ##1 UROW_START |=> !UROW_START)
    else $error("flash update start not a pulse");
  chk_urow_cause: assert property (
    $rose(UROW_START) |-> $past(REQ.wr) && $past(REQ.addr) == 8'h0A
      && $past(REQ.wdata[1]))
    else $error("flash update without done write");
  chk_clk_drop: assert property (
    REQ.wr && REQ.addr == 8'h0A && !REQ.wdata[0]
      && $past(SYS_IN.dbg_en, 4) |=> !SYS_CLK_REQ)
    else $error("clock request not withdrawn");
  chk_clk_enable: assert property (
    $rose(SYS_IN.dbg_en) |-> ##[1:4] SYS_CLK_REQ)
    else $error("enable did not request clock");
  chk_system_reset_active_seen: assert property (
    REQ.rd && REQ.addr == 8'h0B && SYS_RESET_REQ && $past(SYS_RESET_REQ)
      |=> RSP.rdata[5])
    else $error("held reset not shown");
  chk_staged_capture: assert property (
    $changed(UROW_STAGED) |-> UROW_START)
    else $error("staged flag changed outside a commit");
endmodule : dpsc_checker
bind dpsc_top dpsc_checker u_chk (.MCLK(MCLK), .RST_N(RST_N), .REQ(REQ),
  .RSP(RSP), .SYS_IN(SYS_IN), .SYS_CLK_REQ(SYS_CLK_REQ),
  .SYS_RESET_REQ(SYS_RESET_REQ), .UROW_START(UROW_START),
  .UROW_STAGED(UROW_STAGED));
`default_nettype wire

// >>> test/dpsc_tool.sv
`timescale 1ns/1ps
`default_nettype none
module dpsc_tool
  import dpsc_pkg::*;
(
  input  wire logic      MCLK,
  output var  dpsc_req_t REQ,
  input  wire dpsc_rsp_t RSP
);
  initial REQ = '0;
  // One request per call; the pulse drops at the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge MCLK);
    REQ <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge MCLK);
    REQ.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output dpsc_rsp_t r);
    @(posedge MCLK);
    REQ <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge MCLK);
    REQ.rd <= 1'b0;
    #1 r = RSP;
  endtask : rd
endmodule : dpsc_tool
`default_nettype wire

// >>> test/dpsc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dpsc_top_tb
  import dpsc_pkg::*;
;
  logic      mclk;
  logic      rst_n;
  dpsc_req_t req;
  dpsc_rsp_t rsp;
  dpsc_sys_t sys;
  dpsc_sys_t s;
  logic      clk_req;
  logic      rst_req;
  logic      urow_start;
  logic      urow_staged;
  int        fails;
  int        samples_checked;

  dpsc_top dut (.MCLK(mclk), .RST_N(rst_n), .REQ(req), .RSP(rsp),
    .SYS_IN(sys), .SYS_CLK_REQ(clk_req), .SYS_RESET_REQ(rst_req),
    .UROW_START(urow_start), .UROW_STAGED(urow_staged));
  dpsc_tool tool (.MCLK(mclk), .REQ(req), .RSP(rsp));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic read_chk(input logic [7:0] a, input logic [7:0] exp);
    dpsc_rsp_t r;
    tool.rd(a, r);
    check(8'(r.rvalid), 8'h01);
    check(r.rdata, exp);
  endtask : read_chk

  // Inputs pass two synchroniser stages, so allow a few cycles.
  task automatic set_sys;
    @(posedge mclk);
    sys <= s;
    repeat (4) @(posedge mclk);
    #1;
  endtask : set_sys

  task automatic t_after_reset;
    read_chk(8'h0B, 8'h01);
    read_chk(8'h0C, 8'h00);
    tool.wr(8'h0B, 8'hFE);
    tool.wr(8'h0C, 8'h07);
    read_chk(8'h0B, 8'h01);
    read_chk(8'h0C, 8'h00);
  endtask : t_after_reset

  task automatic t_clock;
    s.dbg_en = 1'b1;
    set_sys();
    check(8'(clk_req), 8'h01);
    tool.wr(8'h0A, 8'h00);
    #1 check(8'(clk_req), 8'h00);
    tool.wr(8'h0A, 8'h01);
    #1 check(8'(clk_req), 8'h01);
  endtask : t_clock

  task automatic t_status;
    s.in_sleep = 1'b1;
    s.nvm_ready = 1'b1;
    s.urow_ready = 1'b1;
    s.locked = 1'b0;
    set_sys();
    read_chk(8'h0B, 8'h1C);
    s.erase_fail = 1'b1;
    set_sys();
    read_chk(8'h0B, 8'h5C);
  endtask : t_status

  task automatic t_reset_req;
    tool.wr(8'h08, 8'h59);
    #1 check(8'(rst_req), 8'h01);
    tool.wr(8'h08, 8'h12);
    #1 check(8'(rst_req), 8'h01);
    read_chk(8'h0B, 8'h3C);
    tool.wr(8'h08, 8'h00);
    #1 check(8'(rst_req), 8'h00);
    read_chk(8'h0B, 8'h3C);
    read_chk(8'h0B, 8'h1C);
    s.erase_fail = 1'b0;
    set_sys();
    s.erase_fail = 1'b1;
    set_sys();
    read_chk(8'h0B, 8'h5C);
    s.reset_active = 1'b1;
    set_sys();
    read_chk(8'h0B, 8'h3C);
    s.reset_active = 1'b0;
    set_sys();
    read_chk(8'h0B, 8'h3C);
    read_chk(8'h0B, 8'h1C);
  endtask : t_reset_req

  task automatic t_user_row;
    tool.wr(8'h0A, 8'h03);
    #1 check(8'(urow_start), 8'h00);
    s.urow_key = 1'b1;
    s.staged = 1'b1;
    set_sys();
    tool.wr(8'h0A, 8'h03);
    #1 check(8'(urow_start), 8'h01);
    check(8'(urow_staged), 8'h01);
    @(posedge mclk);
    #1 check(8'(urow_start), 8'h00);
    s.urow_key = 1'b0;
    set_sys();
    s.urow_key = 1'b1;
    s.staged = 1'b0;
    set_sys();
    tool.wr(8'h0A, 8'h03);
    #1 check(8'(urow_staged), 8'h00);
  endtask : t_user_row

  task automatic t_crc;
    logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h3};
    logic [2:0] want  [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h4};
    foreach (codes[i]) begin
      s.crc = codes[i];
      set_sys();
      read_chk(8'h0C, {5'h00, want[i]});
    end
  endtask : t_crc

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  initial begin
    fails = 0;
    samples_checked = 0;
    s = '0;
    s.locked = 1'b1;
    sys = s;
    rst_n = 1'b0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    t_after_reset();
    t_clock();
    t_status();
    t_reset_req();
    t_user_row();
    t_crc();
    test_done();
  end
endmodule : dpsc_top_tb
`default_nettype wire
